// >>> rtl/hdlc_ctrl_pkg.sv
// Package: offsets, field layouts, reset values, codes and types of the command and mode control block
package hdlc_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_COMMAND = 8'h21;
	localparam logic [7:0] OFS_MODE = 8'h22;
	localparam logic [7:0] OFS_TIMER = 8'h23;
	localparam logic [7:0] OFS_LOW_A = 8'h26;
	localparam logic [7:0] OFS_LOW_B = 8'h27;
	localparam logic [7:0] OFS_HIGH_A = 8'h28;
	localparam logic [7:0] OFS_HIGH_B = 8'h29;
	localparam logic [7:0] OFS_CONFIG = 8'h2A;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CMD_RX_RELEASE = 7;
	localparam int CMD_RX_RESET = 6;
	localparam int CMD_NOT_READY = 5;
	localparam int CMD_TIMER_START = 4;
	localparam int CMD_TRANSPARENT = 3;
	localparam int CMD_IFRAME = 2;
	localparam int CMD_MSG_END = 1;
	localparam int CMD_TX_RESET = 0;
	localparam int CFG_BUS_VARIANT = 0;
	localparam int CFG_SERIAL_PORT = 1;
	localparam int CFG_TEST_MODE = 2;
	localparam logic [7:0] MODE_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] TIMER_RESET = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// Fixed address values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] HIGH_GROUP_VALUE = 8'hFC;
	localparam logic [7:0] HIGH_GROUP_MASK = 8'hFD;
	localparam logic [7:0] LOW_BROADCAST = 8'hFF;
	localparam int STUFF_RUN = 5;
	localparam int CMD_EXEC_HALF_DCL = 5;
	localparam int T1_UNIT_DCL = 512;

	// ----------------------------------------------------------------
	// Codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		XM_AUTO_ONE = 3'h0,
		XM_AUTO_TWO = 3'h1,
		XM_PLAIN_ONE = 3'h2,
		XM_PLAIN_TWO = 3'h3,
		XM_RESERVED = 3'h4,
		XM_LOW_ONLY = 3'h5,
		XM_ACCEPT_ALL = 3'h6,
		XM_HIGH_ONLY = 3'h7
	} transfer_mode_e;

	typedef enum logic [2:0] {
		CMD_IDLE = 3'b001,
		CMD_WAIT = 3'b010,
		CMD_FIRE = 3'b100
	} cmd_state_e;

	// Mode register layout
	typedef struct packed {
		transfer_mode_e transfer_mode_code;
		logic timer_mode_bit;
		logic receiver_active_bit;
		logic [2:0] data_port_mode_code;
	} mode_s;

	// Decoded data-port behaviour
	typedef struct packed {
		logic frame_structure;
		logic hdlc_test_if;
		logic monitor_data_xfer;
		logic arbitration_access;
		logic stop_go_eval;
		logic port_mode_reserved;
	} port_cfg_s;

	// One-cycle command actions
	typedef struct packed {
		logic receive_release;
		logic receiver_reset;
		logic seq_counters_clear;
		logic transparent_tx;
		logic iframe_tx;
		logic message_end;
		logic transmitter_reset;
		logic poll_frame_req;
	} cmd_action_s;

endpackage

// >>> rtl/hdlc_command_mode_control.sv
// Command and mode control for a layer-2 frame controller on a serial terminal bus
module hdlc_command_mode_control
	import hdlc_ctrl_pkg::*;
#(
	parameter int T1_UNIT = T1_UNIT_DCL
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic data_clock_in,
	input wire logic [7:0] rx_addr_high_in,
	input wire logic [7:0] rx_addr_low_in,
	input wire logic rx_addr_valid_in,
	output logic rx_frame_accept_out,
	output logic rx_frame_protocol_out,
	output logic receiver_enable_out,
	output logic ack_is_rnr_out,
	output cmd_action_s cmd_action_out,
	output logic timer_running_out,
	output logic timer_expired_out,
	output logic timer_internal_out,
	output port_cfg_s port_cfg_out,
	input wire logic tx_frame_active_in,
	input wire logic tx_bit_valid_in,
	input wire logic tx_bit_in,
	output logic tx_bit_ready_out,
	output logic tx_line_out
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	mode_s mode_q;
	logic [7:0] config_q;
	logic [7:0] timer_value_q;
	logic [7:0] low_a_q;
	logic [7:0] low_b_q;
	logic [7:0] high_a_q;
	logic [7:0] high_b_q;
	logic not_ready_q;
	logic [7:0] cmd_pend_q;
	cmd_state_e cmd_state_q;
	logic dclk_meta_q;
	logic dclk_sync_q;
	logic dclk_prev_q;
	logic dclk_rise;
	logic wr_command;
	logic wr_timer;
	logic auto_mode;
	logic [7:0] rdata_d;
	logic [15:0] t1_count_q;
	logic [3:0] retry_q;
	logic [2:0] ones_q;
	logic stuff_now;

	assign wr_command = reg_wr_in && (reg_addr_in == OFS_COMMAND);
	assign wr_timer = reg_wr_in && (reg_addr_in == OFS_TIMER);
	assign auto_mode = (mode_q.transfer_mode_code == XM_AUTO_ONE) || (mode_q.transfer_mode_code == XM_AUTO_TWO);

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------

	// Mode register holds its value and clears at reset
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			mode_q <= mode_s'(MODE_RESET);
		end else if (reg_wr_in && reg_addr_in == OFS_MODE) begin
			mode_q <= mode_s'(reg_wdata_in);
		end
	end

	// Configuration and programmed address values
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			config_q <= CONFIG_RESET;
			low_a_q <= ADDR_RESET;
			low_b_q <= ADDR_RESET;
			high_a_q <= ADDR_RESET;
			high_b_q <= ADDR_RESET;
			timer_value_q <= TIMER_RESET;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				OFS_CONFIG: config_q <= reg_wdata_in;
				OFS_LOW_A: low_a_q <= reg_wdata_in;
				OFS_LOW_B: low_b_q <= reg_wdata_in;
				OFS_HIGH_A: high_a_q <= reg_wdata_in;
				OFS_HIGH_B: high_b_q <= reg_wdata_in;
				OFS_TIMER: timer_value_q <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Not-ready is a level: every command write reloads it
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			not_ready_q <= 1'b0;
		end else if (wr_command) begin
			not_ready_q <= reg_wdata_in[CMD_NOT_READY];
		end
	end

	// Read data stand in the cycle after the strobe only
	always_comb begin
		rdata_d = READ_ZERO;
		unique case (reg_addr_in)
			OFS_MODE: rdata_d = mode_q;
			OFS_COMMAND: rdata_d = {4'h0, retry_q[2:0] != 3'h0, timer_running_out, cmd_state_q != CMD_IDLE, not_ready_q};
			OFS_TIMER: rdata_d = timer_value_q;
			OFS_CONFIG: rdata_d = config_q;
			OFS_LOW_A: rdata_d = low_a_q;
			OFS_LOW_B: rdata_d = low_b_q;
			OFS_HIGH_A: rdata_d = high_a_q;
			OFS_HIGH_B: rdata_d = high_b_q;
			default: rdata_d = READ_ZERO;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= READ_ZERO;
		end else begin
			reg_rdata_out <= reg_rd_in ? rdata_d : READ_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// Data clock sampling
	// ----------------------------------------------------------------

	// Two flops before any logic looks at the data clock
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			dclk_meta_q <= 1'b0;
			dclk_sync_q <= 1'b0;
			dclk_prev_q <= 1'b0;
		end else begin
			dclk_meta_q <= data_clock_in;
			dclk_sync_q <= dclk_meta_q;
			dclk_prev_q <= dclk_sync_q;
		end
	end

	assign dclk_rise = dclk_sync_q && !dclk_prev_q;

	// ----------------------------------------------------------------
	// Command execution
	// ----------------------------------------------------------------

	// A written command waits for the next data-clock rise and then fires;
	// a second write before that is merged rather than dropped, which is
	// kinder than losing it, though software must still keep the spacing.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			cmd_state_q <= CMD_IDLE;
			cmd_pend_q <= 8'h00;
		end else begin
			unique case (cmd_state_q)
				CMD_IDLE: begin
					if (wr_command) begin
						cmd_pend_q <= reg_wdata_in;
						cmd_state_q <= CMD_WAIT;
					end
				end
				CMD_WAIT: begin
					if (wr_command) begin
						cmd_pend_q <= cmd_pend_q | reg_wdata_in;
					end
					if (dclk_rise) begin
						cmd_state_q <= CMD_FIRE;
					end
				end
				CMD_FIRE: begin
					cmd_pend_q <= wr_command ? reg_wdata_in : 8'h00;
					cmd_state_q <= wr_command ? CMD_WAIT : CMD_IDLE;
				end
				default: cmd_state_q <= CMD_IDLE;
			endcase
		end
	end

	// Action pulses, one cycle each, registered
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			cmd_action_out <= '0;
		end else begin
			cmd_action_out <= '0;
			if (cmd_state_q == CMD_FIRE) begin
				cmd_action_out.receive_release <= cmd_pend_q[CMD_RX_RELEASE];
				cmd_action_out.receiver_reset <= cmd_pend_q[CMD_RX_RESET];
				cmd_action_out.seq_counters_clear <= cmd_pend_q[CMD_RX_RESET] && auto_mode;
				cmd_action_out.transparent_tx <= cmd_pend_q[CMD_TRANSPARENT];
				cmd_action_out.iframe_tx <= cmd_pend_q[CMD_IFRAME] && auto_mode;
				cmd_action_out.message_end <= cmd_pend_q[CMD_MSG_END];
				cmd_action_out.transmitter_reset <= cmd_pend_q[CMD_TX_RESET];
				cmd_action_out.poll_frame_req <= cmd_pend_q[CMD_TIMER_START] && mode_q.timer_mode_bit;
			end
		end
	end

	// Acknowledge type only matters in auto mode
	assign ack_is_rnr_out = auto_mode && not_ready_q;
	assign receiver_enable_out = mode_q.receiver_active_bit;
	assign timer_internal_out = mode_q.timer_mode_bit && auto_mode;

	// ----------------------------------------------------------------
	// Timer
	// ----------------------------------------------------------------

	// Counts data-clock rises; T1 is (VALUE+1) units, and CNT adds repeats.
	// CNT of 7 repeats forever.
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			timer_running_out <= 1'b0;
			timer_expired_out <= 1'b0;
			t1_count_q <= 16'h0000;
			retry_q <= 4'h0;
		end else begin
			timer_expired_out <= 1'b0;
			if (wr_timer) begin
				timer_running_out <= 1'b0;
			end else if (cmd_state_q == CMD_FIRE && cmd_pend_q[CMD_TIMER_START]) begin
				timer_running_out <= 1'b1;
				t1_count_q <= 16'((32'(timer_value_q[4:0]) + 32'h1) * 32'(T1_UNIT));
				retry_q <= {1'b0, timer_value_q[7:5]};
			end else if (timer_running_out && dclk_rise) begin
				if (t1_count_q > 16'h0001) begin
					t1_count_q <= t1_count_q - 16'h0001;
				end else if (retry_q == 4'h0) begin
					timer_running_out <= 1'b0;
					timer_expired_out <= 1'b1;
				end else begin
					t1_count_q <= 16'((32'(timer_value_q[4:0]) + 32'h1) * 32'(T1_UNIT));
					retry_q <= (retry_q == 4'h7) ? retry_q : retry_q - 4'h1;
					timer_expired_out <= (retry_q == 4'h7);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Address comparison
	// ----------------------------------------------------------------

	logic high_hit;
	logic high_first;
	logic low_hit;
	logic low_first;
	logic accept_d;
	logic protocol_d;

	assign high_first = (rx_addr_high_in == high_a_q);
	assign high_hit = high_first || (rx_addr_high_in == high_b_q) ||
		((rx_addr_high_in & HIGH_GROUP_MASK) == HIGH_GROUP_VALUE);
	assign low_first = (rx_addr_low_in == low_a_q);
	assign low_hit = low_first || (rx_addr_low_in == low_b_q) || (rx_addr_low_in == LOW_BROADCAST);

	// Mode decides which bytes are compared
	always_comb begin
		accept_d = 1'b0;
		protocol_d = 1'b0;
		unique case (mode_q.transfer_mode_code)
			XM_AUTO_ONE: begin
				accept_d = low_first || (rx_addr_low_in == low_b_q);
				protocol_d = low_first;
			end
			XM_AUTO_TWO: begin
				accept_d = high_hit && low_hit;
				protocol_d = high_first && low_first;
			end
			XM_PLAIN_ONE: accept_d = low_first || (rx_addr_low_in == low_b_q);
			XM_PLAIN_TWO: accept_d = high_hit && low_hit;
			XM_RESERVED: accept_d = 1'b0;
			XM_LOW_ONLY: accept_d = low_hit;
			XM_ACCEPT_ALL: accept_d = 1'b1;
			XM_HIGH_ONLY: accept_d = high_hit;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			rx_frame_accept_out <= 1'b0;
			rx_frame_protocol_out <= 1'b0;
		end else begin
			rx_frame_accept_out <= rx_addr_valid_in && accept_d && mode_q.receiver_active_bit;
			rx_frame_protocol_out <= rx_addr_valid_in && protocol_d && mode_q.receiver_active_bit;
		end
	end

	// ----------------------------------------------------------------
	// Data-port mode decode
	// ----------------------------------------------------------------

	// Variant chosen by the configuration register
	always_comb begin
		port_cfg_out = '0;
		if (!config_q[CFG_BUS_VARIANT]) begin
			port_cfg_out.frame_structure = !mode_q.data_port_mode_code[2];
			port_cfg_out.arbitration_access = !mode_q.data_port_mode_code[2];
			port_cfg_out.monitor_data_xfer = (mode_q.data_port_mode_code[2:1] == 2'h1) &&
				config_q[CFG_TEST_MODE];
			port_cfg_out.stop_go_eval = !mode_q.data_port_mode_code[2] && mode_q.data_port_mode_code[0];
			port_cfg_out.hdlc_test_if = mode_q.data_port_mode_code[2] &&
				(mode_q.data_port_mode_code[1:0] != 2'h0);
			port_cfg_out.port_mode_reserved = (mode_q.data_port_mode_code == 3'h4);
		end else begin
			port_cfg_out.frame_structure = !mode_q.data_port_mode_code[2] &&
				(!config_q[CFG_SERIAL_PORT] || mode_q.data_port_mode_code[1]);
			port_cfg_out.arbitration_access = (mode_q.data_port_mode_code[2:1] == 2'h0);
			port_cfg_out.stop_go_eval = !mode_q.data_port_mode_code[2] && mode_q.data_port_mode_code[0];
			port_cfg_out.port_mode_reserved = mode_q.data_port_mode_code[2];
		end
	end

	// ----------------------------------------------------------------
	// Transmit bit stuffing
	// ----------------------------------------------------------------

	// A zero goes out after five ones; the source is held off for that bit.
	// Outside frames the line idles high and the run count is cleared so
	// each frame starts counting ones from zero.
	assign stuff_now = (ones_q == 3'(STUFF_RUN));
	assign tx_bit_ready_out = dclk_rise && tx_frame_active_in && !stuff_now;

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ones_q <= 3'h0;
			tx_line_out <= 1'b1;
		end else if (!tx_frame_active_in || cmd_action_out.transmitter_reset) begin
			ones_q <= 3'h0;
			if (dclk_rise) begin
				tx_line_out <= 1'b1;
			end
		end else if (dclk_rise) begin
			if (stuff_now) begin
				tx_line_out <= 1'b0;
				ones_q <= 3'h0;
			end else if (tx_bit_valid_in) begin
				tx_line_out <= tx_bit_in;
				ones_q <= tx_bit_in ? ones_q + 3'h1 : 3'h0;
			end
		end
	end

endmodule

// >>> tb/hdlc_ctrl_properties.sv
// Checker: port-level properties of the command and mode control block
module hdlc_ctrl_props
	import hdlc_ctrl_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic rx_addr_valid_in,
	input wire logic rx_frame_accept_out,
	input wire logic ack_is_rnr_out,
	input wire cmd_action_s cmd_action_out,
	input wire logic timer_running_out,
	input wire port_cfg_s port_cfg_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mode_q;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	// ----
	// Shadow of the mode register
	// ----
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			mode_q <= 8'h00;
		end else if (reg_wr_in && reg_addr_in == OFS_MODE) begin
			mode_q <= reg_wdata_in;
		end
	end
	// ----
	// Properties
	// ----
	a_mode_read_back: assert property (reg_rd_in && reg_addr_in == OFS_MODE |=> reg_rdata_out == mode_q)
		else $error("mode read back differs");
	a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("read data not zero outside read");
	a_accept_needs_rac: assert property (rx_frame_accept_out |-> $past(mode_q[3]))
		else $error("frame accepted with receiver off");
	a_all_frames_pass: assert property (rx_addr_valid_in && mode_q[7:5] == 3'h6 && mode_q[3] |=> rx_frame_accept_out)
		else $error("open mode rejected a frame");
	a_reserved_rejects: assert property (rx_addr_valid_in && mode_q[7:5] == 3'h4 |=> !rx_frame_accept_out)
		else $error("reserved mode accepted a frame");
	a_iframe_auto_only: assert property (cmd_action_out.iframe_tx |-> $past(mode_q[7:6]) == 2'h0)
		else $error("info frame outside auto mode");
	a_poll_timer_mode: assert property (cmd_action_out.poll_frame_req |-> $past(mode_q[4]))
		else $error("poll frame with external timer");
	a_xfer_fires_soon: assert property (reg_wr_in && reg_addr_in == OFS_COMMAND && reg_wdata_in[CMD_TRANSPARENT]
		|-> ##[2:20] cmd_action_out.transparent_tx)
		else $error("transmit command not executed in time");
	a_pulse_single: assert property (cmd_action_out != 8'h00 |=> cmd_action_out == 8'h00)
		else $error("command action longer than one cycle");
	a_timer_stop_write: assert property (reg_wr_in && reg_addr_in == OFS_TIMER |=> !timer_running_out)
		else $error("timer still running after timer write");
	a_stop_go_decode: assert property (port_cfg_out.stop_go_eval == (!mode_q[2] && mode_q[0]))
		else $error("stop/go decode wrong");
	a_rnr_auto_only: assert property (ack_is_rnr_out |-> mode_q[7:6] == 2'h0)
		else $error("not-ready answer outside auto mode");
endmodule

bind hdlc_command_mode_control hdlc_ctrl_props hdlc_ctrl_props_i (.mclk_in, .rst_n_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .rx_addr_valid_in, .rx_frame_accept_out,
	.ack_is_rnr_out, .cmd_action_out, .timer_running_out, .port_cfg_out);

// >>> tb/l1_link_model.sv
// Partner: layer-1 side of the serial bus, data clock source and line monitor
module l1_link_model (
	output logic dclk_out,
	input wire logic line_in,
	input wire logic count_en_in,
	output int max_run_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int run;
	// Bus data clock runs free, 800 ns period; paces command execution
	initial begin
		dclk_out = 1'h0;
		forever #400 dclk_out = ~dclk_out;
	end
	// Longest run of ones seen on the line during a frame; one process owns the result
	initial begin
		max_run_out = 0;
		forever begin
			@(posedge dclk_out);
			if (!count_en_in || !line_in) begin
				run = 0;
			end else begin
				run = run + 1;
				if (run > max_run_out) begin
					max_run_out = run;
				end
			end
		end
	end
endmodule

// >>> tb/hdlc_command_mode_control_bench.sv
// Testbench: register access, commands, address filter, timer, port decode, bit stuffing
module hdlc_command_mode_control_bench
	import hdlc_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in, rst_n_in, reg_wr_in, reg_rd_in, dclk, rx_valid, tx_act, tx_val, tx_bit;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rx_high, rx_low;
	logic accept, rx_proto, rx_en, receiver_not_ready_bit, t_run, t_exp, t_int, line, rdy;
	cmd_action_s act;
	port_cfg_s pcfg;
	int bad_count, checks_done, cyc, max_run, rdy_count;
	logic [7:0] ct [7] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01, 8'h10};
	logic [7:0] ae [7] = '{8'h80, 8'h60, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
	logic [24:0] at [10] = '{{8'h08, 8'h00, 8'h12, 1'h1}, {8'h08, 8'h00, 8'h14, 1'h0},
		{8'h28, 8'hFE, 8'hFF, 1'h1}, {8'h28, 8'h44, 8'h13, 1'h0}, {8'hC8, 8'h44, 8'h77, 1'h1},
		{8'h88, 8'hFC, 8'hFF, 1'h0}, {8'hA8, 8'h44, 8'hFF, 1'h1}, {8'hE8, 8'hFC, 8'h00, 1'h1},
		{8'hE8, 8'h44, 8'h00, 1'h0}, {8'hC0, 8'h44, 8'h77, 1'h0}};

	hdlc_command_mode_control #(.T1_UNIT(2)) hdlc_command_mode_control_i (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .data_clock_in(dclk), .rx_addr_high_in(rx_high),
		.rx_addr_low_in(rx_low), .rx_addr_valid_in(rx_valid), .rx_frame_accept_out(accept),
		.rx_frame_protocol_out(rx_proto), .receiver_enable_out(rx_en), .ack_is_rnr_out(receiver_not_ready_bit),
		.cmd_action_out(act), .timer_running_out(t_run), .timer_expired_out(t_exp),
		.timer_internal_out(t_int), .port_cfg_out(pcfg), .tx_frame_active_in(tx_act),
		.tx_bit_valid_in(tx_val), .tx_bit_in(tx_bit), .tx_bit_ready_out(rdy), .tx_line_out(line));
	l1_link_model l1_link_model_i (.dclk_out(dclk), .line_in(line), .count_en_in(tx_act),
		.max_run_out(max_run));

	// ----
	// Clock and hang guard
	// ----
	initial begin
		mclk_in = 1'h0;
		forever #50 mclk_in = ~mclk_in;
	end
	// A run should need about 800 cycles; 6000 means a hang
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			print_verdict();
		end
	end
	// Bits taken by the stuffer, counted for the run-of-ones scenario
	always @(posedge mclk_in) begin
		if (rdy === 1'h1) begin
			rdy_count++;
		end
	end

	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		reg_wr_in <= 1'h1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge mclk_in);
		reg_wr_in <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_in);
		reg_rd_in <= 1'h1;
		reg_addr_in <= a;
		@(posedge mclk_in);
		reg_rd_in <= 1'h0;
		#1 chk(reg_rdata_out, e);
	endtask
	// Spacing of 30 cycles keeps commands over 2.5 data clocks apart
	task automatic do_cmd(input logic [7:0] c, input logic [7:0] e);
		logic [7:0] acc;
		wr(OFS_COMMAND, c);
		acc = 8'h00;
		repeat (30) begin
			@(posedge mclk_in);
			#1 acc = acc | act;
		end
		chk(acc, e);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		{rst_n_in, reg_wr_in, reg_rd_in, rx_valid, tx_act, tx_val, tx_bit} = 7'h00;
		{reg_addr_in, reg_wdata_in, rx_high, rx_low} = 32'h0000_0000;
		repeat (16) @(posedge mclk_in);
		rst_n_in <= 1'h1;
		rd(OFS_MODE, 8'h00);
		rd(8'h40, 8'h00);
		wr(OFS_MODE, 8'h5A);
		rd(OFS_MODE, 8'h5A);
		// Auto mode, internal timer: every command bit once
		wr(OFS_MODE, 8'h18);
		chk({7'h00, t_int}, 8'h01);
		chk({7'h00, rx_en}, 8'h01);
		// A long period keeps the started timer running until it is looked at
		wr(OFS_TIMER, 8'h1F);
		for (int i = 0; i < 7; i++) do_cmd(ct[i], ae[i]);
		chk({7'h00, t_run}, 8'h01);
		wr(OFS_TIMER, 8'h03);
		@(posedge mclk_in);
		#1 chk({7'h00, t_run}, 8'h00);
		do_cmd(8'h20, 8'h00);
		chk({7'h00, receiver_not_ready_bit}, 8'h01);
		// Plain mode, external timer: no sequence clear, no info frame, no poll
		wr(OFS_MODE, 8'h48);
		chk({7'h00, t_int}, 8'h00);
		chk({7'h00, receiver_not_ready_bit}, 8'h00);
		do_cmd(8'h40, 8'h40);
		do_cmd(8'h04, 8'h00);
		do_cmd(8'h08, 8'h10);
		do_cmd(8'h10, 8'h00);
		for (int i = 0; i < 200 && t_exp !== 1'h1; i++) @(posedge mclk_in) #1;
		chk({7'h00, t_exp}, 8'h01);
		@(posedge mclk_in);
		#1 chk({7'h00, t_run}, 8'h00);
		// Address filter across transfer modes
		wr(OFS_LOW_A, 8'h12);
		wr(OFS_LOW_B, 8'h13);
		wr(OFS_HIGH_A, 8'h30);
		wr(OFS_HIGH_B, 8'h31);
		foreach (at[i]) begin
			wr(OFS_MODE, at[i][24:17]);
			@(posedge mclk_in);
			rx_valid <= 1'h1;
			{rx_high, rx_low} <= at[i][16:1];
			@(posedge mclk_in);
			rx_valid <= 1'h0;
			#1 chk({7'h00, accept}, {7'h00, at[i][0]});
			// Only the first entry hits the first programmed low address in an auto mode
			chk({7'h00, rx_proto}, {7'h00, i == 0});
		end
		// Data-port decode for both bus variants
		// Test mode on, so the monitor channel may carry data
		wr(OFS_CONFIG, 8'h04);
		wr(OFS_MODE, 8'h05);
		chk({7'h00, pcfg.hdlc_test_if}, 8'h01);
		wr(OFS_MODE, 8'h02);
		chk({7'h00, pcfg.monitor_data_xfer}, 8'h01);
		wr(OFS_CONFIG, 8'h01);
		wr(OFS_MODE, 8'h00);
		chk({7'h00, rx_en}, 8'h00);
		// One layer-2 device here: the arbitration address outside stays 111
		chk({7'h00, pcfg.arbitration_access}, 8'h01);
		wr(OFS_MODE, 8'h04);
		chk({7'h00, pcfg.port_mode_reserved}, 8'h01);
		// Long run of ones: zeros first so idle ones do not count
		@(posedge mclk_in);
		{tx_act, tx_val, tx_bit} <= 3'h6;
		repeat (24) @(posedge mclk_in);
		tx_bit <= 1'h1;
		repeat (240) @(posedge mclk_in);
		// Three zeros taken, then 30 rises of which every sixth is a stuffed zero
		#1 chk(rdy_count[7:0], 8'h1C);
		chk(max_run[7:0], 8'h05);
		tx_act <= 1'h0;
		print_verdict();
	end
endmodule
